// ===== hw/cuer_pkg.sv
// Operation
// - Frame type: none, single, double-adjacent, uncorrectable
// - Column type adds cross-frame double-adjacent codes
// - Column check alerts, then frame check locates
// - Locatable upset gives two ordered alert pulses
// - Alert high from detection until report ready
// - Report final only after second pulse falls
// - Unlocatable upset gives a single alert pulse
// - Report readable by core and JTAG shift
// - Scrubbing corrects correctable upsets automatically
// - Report is 78 bits with listed fields
// - Update registers load then shift when enabled
package cuer_pkg;

    // ************************************************
    // Report layout
    // ************************************************
    localparam int REPORT_W      = 78;
    localparam int FRAME_ADDR_LSB = 0;
    localparam int FRAME_ADDR_W  = 16;
    localparam int COL_DW_LSB    = 16;
    localparam int COL_DW_W      = 2;
    localparam int COL_BIT_LSB   = 18;
    localparam int COL_BIT_W     = 5;
    localparam int COL_TYPE_LSB  = 23;
    localparam int SYND_LSB      = 26;
    localparam int SYND_W        = 32;
    localparam int FRM_DW_LSB    = 58;
    localparam int FRM_DW_W      = 10;
    localparam int FRM_BIT_LSB   = 68;
    localparam int FRM_TYPE_LSB  = 73;
    localparam int RSVD_LSB      = 76;
    localparam int COL_UPD_LSB   = 77;
    localparam int TYPE_W        = 3;

    // ************************************************
    // Error type codes
    // ************************************************
    localparam logic [2:0] TYPE_NONE    = 3'h0;
    localparam logic [2:0] TYPE_SINGLE  = 3'h1;
    localparam logic [2:0] TYPE_DADJ    = 3'h2;
    localparam logic [2:0] TYPE_XFRM_A  = 3'h4;
    localparam logic [2:0] TYPE_XFRM_B  = 3'h6;
    localparam logic [2:0] TYPE_UNCORR  = 3'h7;

    // ************************************************
    // Timing and reset values
    // ************************************************
    localparam int UPDATE_DELAY  = 1;
    localparam int FRAME_LOC_CYC = 4;
    localparam int SCRUB_CYC     = 4;
    localparam int ALERT_GAP_CYC = 2;
    localparam logic [77:0] REPORT_RST = 78'h0;

endpackage : cuer_pkg

// ===== hw/cuer_shift.sv
// Update register plus shift register for one reading port
module cuer_shift #(
    parameter int W = cuer_pkg::REPORT_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Report source
    input  wire logic [W-1:0] report,
    input  wire logic         report_valid,
    // Reader side
    input  wire logic         upd_en,
    input  wire logic         load,
    input  wire logic         shift,
    output logic              sdo
);

    typedef struct packed {
        logic [W-1:0] upd;
        logic         pend;
        logic [W-1:0] sh;
    } cuer_sh_t;

    cuer_sh_t st;
    cuer_sh_t next_st;

    // ************************************************
    // Update and shift logic
    // ************************************************
    always_comb begin
        next_st = st;
        if (st.pend && !upd_en) begin
            next_st.upd  = report;
            next_st.pend = 1'b0;
        end
        if (report_valid) begin
            next_st.pend = 1'b1;  // Load one cycle after validation
        end
        if (load && upd_en) begin
            next_st.sh = st.upd;
        end else if (shift) begin
            next_st.sh = {1'b0, st.sh[W-1:1]};  // LSB first
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sdo = st.sh[0];

endmodule : cuer_shift

// ===== hw/cuer_top.sv
// Upset reporting: alert sequencing, report capture, scrub and readout
module cuer_top (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    // Column check result (from check engines, same clock)
    input  wire logic        COL_DETECT,
    input  wire logic [2:0]  COL_TYPE,
    input  wire logic [15:0] COL_FRAME,
    input  wire logic [1:0]  COL_DW,
    input  wire logic [4:0]  COL_BIT,
    input  wire logic        COL_UPD_ERR,
    // Frame check result
    input  wire logic        FRM_DONE,
    input  wire logic [2:0]  FRM_TYPE,
    input  wire logic [9:0]  FRM_DW,
    input  wire logic [4:0]  FRM_BIT,
    input  wire logic [31:0] FRM_SYND,
    // Scrubbing
    input  wire logic        SCRUB_EN,
    output logic             SCRUB_REQ,
    output logic             BUSY,
    // Alert
    output logic             UPSET_ALERT,
    // Core shift port
    input  wire logic        CORE_UPD_EN,
    input  wire logic        CORE_LOAD,
    input  wire logic        CORE_SHIFT,
    output logic             CORE_SDO,
    // JTAG shift port (report_shift_instruction selected)
    input  wire logic        JTAG_SEL,
    input  wire logic        JTAG_UPD_EN,
    input  wire logic        JTAG_LOAD,
    input  wire logic        JTAG_SHIFT,
    output logic             JTAG_SDO
);

    typedef enum {S_IDLE, S_COL_ALERT, S_GAP, S_FRM_ALERT, S_SCRUB} cuer_state_t;

    typedef struct packed {
        cuer_state_t  state;
        logic [77:0]  report;
        logic         alert;
        logic         valid;
        logic         scrub;
        logic [3:0]   cnt;
    } cuer_st_t;

    cuer_st_t st;
    cuer_st_t next_st;

    // Correctable when not uncorrectable and not clean
    function automatic logic correctable(input logic [2:0] t);
        correctable = (t != cuer_pkg::TYPE_NONE) && (t != cuer_pkg::TYPE_UNCORR);
    endfunction : correctable

    // ************************************************
    // Alert sequencer
    // ************************************************
    always_comb begin
        next_st       = st;
        next_st.valid = 1'b0;
        next_st.scrub = 1'b0;
        case (st.state)
            S_IDLE: begin
                if (COL_DETECT) begin
                    next_st.alert = 1'b1;  // immediate alert
                    next_st.report[cuer_pkg::FRAME_ADDR_LSB +: cuer_pkg::FRAME_ADDR_W]
                        = COL_FRAME;
                    next_st.report[cuer_pkg::COL_DW_LSB +: cuer_pkg::COL_DW_W] = COL_DW;
                    next_st.report[cuer_pkg::COL_BIT_LSB +: 5] = COL_BIT;
                    next_st.report[cuer_pkg::COL_TYPE_LSB +: cuer_pkg::TYPE_W] = COL_TYPE;
                    next_st.report[cuer_pkg::COL_UPD_LSB] = COL_UPD_ERR;
                    next_st.report[cuer_pkg::RSVD_LSB] = 1'b0;
                    next_st.cnt   = 4'(cuer_pkg::FRAME_LOC_CYC);
                    next_st.state = S_COL_ALERT;
                end
            end
            S_COL_ALERT: begin
                // Hold alert until column part ready
                if (st.cnt != 4'h0) begin
                    next_st.cnt = st.cnt - 4'h1;
                end else begin
                    next_st.alert = 1'b0;
                    next_st.valid = 1'b1;
                    if (st.report[cuer_pkg::COL_TYPE_LSB +: 3] == cuer_pkg::TYPE_UNCORR) begin
                        next_st.state = S_IDLE;
                    end else begin
                        next_st.cnt   = 4'(cuer_pkg::ALERT_GAP_CYC);
                        next_st.state = S_GAP;
                    end
                end
            end
            S_GAP: begin
                if (st.cnt != 4'h0) begin
                    next_st.cnt = st.cnt - 4'h1;
                end else begin
                    next_st.alert = 1'b1;
                    next_st.state = S_FRM_ALERT;
                end
            end
            S_FRM_ALERT: begin
                // Report final at this falling edge
                if (FRM_DONE) begin
                    next_st.report[cuer_pkg::FRM_TYPE_LSB +: cuer_pkg::TYPE_W] = FRM_TYPE;
                    next_st.report[cuer_pkg::FRM_DW_LSB +: cuer_pkg::FRM_DW_W] = FRM_DW;
                    next_st.report[cuer_pkg::FRM_BIT_LSB +: 5] = FRM_BIT;
                    next_st.report[cuer_pkg::SYND_LSB +: cuer_pkg::SYND_W] = FRM_SYND;
                    next_st.alert = 1'b0;
                    next_st.valid = 1'b1;
                    if (SCRUB_EN && correctable(FRM_TYPE)) begin
                        next_st.cnt   = 4'(cuer_pkg::SCRUB_CYC);
                        next_st.scrub = 1'b1;
                        next_st.state = S_SCRUB;
                    end else begin
                        next_st.state = S_IDLE;
                    end
                end
            end
            S_SCRUB: begin
                // Detection paused while the flipped bit is rewritten
                if (st.cnt != 4'h0) begin
                    next_st.cnt = st.cnt - 4'h1;
                end else begin
                    next_st.state = S_IDLE;
                end
            end
            default: begin
                next_st.state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            st <= '{state: S_IDLE, report: cuer_pkg::REPORT_RST, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign UPSET_ALERT = st.alert;
    assign SCRUB_REQ   = st.scrub;
    assign BUSY        = (st.state != S_IDLE);

    // ************************************************
    // Readout ports
    // ************************************************
    // Core-side shift path
    cuer_shift #(.W(cuer_pkg::REPORT_W)) u_core (
        .clk          (SYS_CLK),
        .nrst         (NRST),
        .report       (st.report),
        .report_valid (st.valid),
        .upd_en       (CORE_UPD_EN),
        .load         (CORE_LOAD),
        .shift        (CORE_SHIFT),
        .sdo          (CORE_SDO)
    );

    // JTAG shift path, gated by instruction
    cuer_shift #(.W(cuer_pkg::REPORT_W)) u_jtag (
        .clk          (SYS_CLK),
        .nrst         (NRST),
        .report       (st.report),
        .report_valid (st.valid),
        .upd_en       (JTAG_UPD_EN),
        .load         (JTAG_LOAD && JTAG_SEL),
        .shift        (JTAG_SHIFT && JTAG_SEL),
        .sdo          (JTAG_SDO)
    );

endmodule : cuer_top

// ===== testbench/cuer_assertions.sv
module cuer_assertions (
    // Watched top ports
    input wire logic       SYS_CLK,
    input wire logic       NRST,
    input wire logic       COL_DETECT,
    input wire logic [2:0] COL_TYPE,
    input wire logic       FRM_DONE,
    input wire logic [2:0] FRM_TYPE,
    input wire logic       SCRUB_EN,
    input wire logic       SCRUB_REQ,
    input wire logic       BUSY,
    input wire logic       UPSET_ALERT
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    // Takes; alert must be low so a held detect counts once
    wire logic take = COL_DETECT && !BUSY && !UPSET_ALERT;
    wire logic fin  = FRM_DONE && UPSET_ALERT;
    wire logic fix  = fin && SCRUB_EN && FRM_TYPE != 3'h0 && FRM_TYPE != 3'h7;
    // Column pulse then gap
    sequence s_col;
        UPSET_ALERT [*5] ##1 !UPSET_ALERT [*3];
    endsequence
    a_two_pulses: assert property (take && COL_TYPE != 3'h7 |=> s_col ##1 UPSET_ALERT)
        else $error("second pulse missing");
    a_one_pulse: assert property (take && COL_TYPE == 3'h7 |=> s_col ##1 !UPSET_ALERT [*8])
        else $error("unlocatable upset pulsed twice");
    a_col_first: assert property (take |=> !SCRUB_REQ throughout s_col)
        else $error("scrub before frame check");
    a_final_fall: assert property (fin |=> !UPSET_ALERT)
        else $error("alert held after frame result");
    a_scrub_start: assert property (fix |=> SCRUB_REQ)
        else $error("scrub not requested");
    a_scrub_none: assert property (fin && !fix |=> !SCRUB_REQ [*6])
        else $error("scrub requested wrongly");
    a_scrub_pulse: assert property (SCRUB_REQ |=> !SCRUB_REQ)
        else $error("scrub request too long");
    a_alert_quiet: assert property (!BUSY && !UPSET_ALERT && !COL_DETECT |=> !UPSET_ALERT)
        else $error("alert without detection");
endmodule : cuer_assertions

bind cuer_top cuer_assertions u_chk (.SYS_CLK(SYS_CLK), .NRST(NRST), .COL_DETECT(COL_DETECT),
    .COL_TYPE(COL_TYPE), .FRM_DONE(FRM_DONE), .FRM_TYPE(FRM_TYPE), .SCRUB_EN(SCRUB_EN),
    .SCRUB_REQ(SCRUB_REQ), .BUSY(BUSY), .UPSET_ALERT(UPSET_ALERT));

// ===== testbench/cuer_reader.sv
// Unloading logic on one shift port
module cuer_reader (
    input  wire logic        clk,
    input  wire logic        alert,
    input  wire logic        sdo,
    input  wire logic [1:0]  pulses,
    output logic             upd_en,
    output logic             load,
    output logic             shift,
    output logic [77:0]      report,
    output logic             done
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wait for the last expected fall, then load and shift 78 bits LSB first
    initial begin
        automatic int falls = 0;
        automatic logic prev = 1'b0;
        {upd_en, load, shift, done} = 4'h0;
        report = 78'h0;
        forever begin
            @(posedge clk);
            #1;
            if (pulses == 2'd0) begin
                falls = 0;
                done = 1'b0;
            end
            // read only after the final fall
            if (prev && !alert) falls++;
            prev = alert;
            if (pulses != 2'd0 && falls == int'(pulses)) begin
                falls = 0;
                // leave room for the update reload, then freeze it
                repeat (4) @(posedge clk);
                #1 upd_en = 1'b1;
                @(posedge clk);
                #1 load = 1'b1;
                @(posedge clk);
                #1 load = 1'b0;
                // slow shifting suits a registered or direct output
                for (int i = 0; i < 78; i++) begin
                    @(posedge clk);
                    #1 report[i] = sdo;
                    shift = 1'b1;
                    @(posedge clk);
                    #1 shift = 1'b0;
                end
                upd_en = 1'b0;
                done = 1'b1;
            end
        end
    end
endmodule : cuer_reader

// ===== testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, nrst = 1'b0, col_detect = 1'b0, col_upd_err = 1'b0;
    logic        frm_done = 1'b0, scrub_en = 1'b0, alert, busy, scrub_req, c_done, j_done;
    logic [2:0]  col_type = 3'h0, frm_type = 3'h0;
    logic [15:0] col_frame = 16'h0;
    logic [1:0]  col_dw = 2'h0, pulses = 2'h0;
    logic [4:0]  col_bit = 5'h0, frm_bit = 5'h0;
    logic [9:0]  frm_dw = 10'h0;
    logic [31:0] frm_synd = 32'h0;
    logic        c_upd, c_load, c_shift, c_sdo, j_upd, j_load, j_shift, j_sdo;
    logic [77:0] c_rep, j_rep;
    logic [2:0]  ftab [7] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h0, 3'h3, 3'h1};
    int          bad_count = 0, compares = 0;
    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;
    cuer_top DUT (.SYS_CLK(sys_clk), .NRST(nrst), .COL_DETECT(col_detect), .COL_TYPE(col_type),
        .COL_FRAME(col_frame), .COL_DW(col_dw), .COL_BIT(col_bit), .COL_UPD_ERR(col_upd_err),
        .FRM_DONE(frm_done), .FRM_TYPE(frm_type), .FRM_DW(frm_dw), .FRM_BIT(frm_bit),
        .FRM_SYND(frm_synd), .SCRUB_EN(scrub_en), .SCRUB_REQ(scrub_req), .BUSY(busy),
        .UPSET_ALERT(alert), .CORE_UPD_EN(c_upd), .CORE_LOAD(c_load), .CORE_SHIFT(c_shift),
        .CORE_SDO(c_sdo), .JTAG_SEL(1'b1), .JTAG_UPD_EN(j_upd), .JTAG_LOAD(j_load),
        .JTAG_SHIFT(j_shift), .JTAG_SDO(j_sdo));
    cuer_reader u_core (.clk(sys_clk), .alert(alert), .sdo(c_sdo), .pulses(pulses),
        .upd_en(c_upd), .load(c_load), .shift(c_shift), .report(c_rep), .done(c_done));
    cuer_reader u_jtag (.clk(sys_clk), .alert(alert), .sdo(j_sdo), .pulses(pulses),
        .upd_en(j_upd), .load(j_load), .shift(j_shift), .report(j_rep), .done(j_done));
    task automatic wrap_up;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string what, input logic [77:0] exp, input logic [77:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Split a type code into {uncorrectable, double-adjacent, single}
    function automatic logic [2:0] decode_kind(input logic [2:0] t);
        return {t == 3'h7, t[2:1] == 2'b01, t == 3'h1};
    endfunction : decode_kind
    // Column part of the report for case i
    function automatic logic [77:0] col_exp(input logic [7:0] i, input logic [2:0] ct);
        return {i[0], 51'h0, ct, 5'h1f - i[4:0], i[1:0], 8'ha5, i};
    endfunction : col_exp
    // Bounded wait for idle; a second detect is held one cycle while busy
    task automatic detect(input logic [7:0] i, input logic [2:0] ct, output logic [8:0] shape);
        int n;
        for (n = 0; n < 100 && (busy !== 1'b0 || alert !== 1'b0); n++) @(negedge sys_clk);
        if (n == 100) check("idle wait", 78'h0, 78'h1);
        if (n == 100) wrap_up();
        @(posedge sys_clk);
        {col_detect, col_type, col_frame, col_dw} <= {1'b1, ct, 8'ha5, i, i[1:0]};
        {col_bit, col_upd_err, scrub_en} <= {5'h1f - i[4:0], i[0], i[0]};
        pulses <= (ct == 3'h7) ? 2'd1 : 2'd2;
        for (int k = 0; k < 9; k++) begin
            @(posedge sys_clk);
            if (k == 0) col_frame <= ~{8'ha5, i};
            if (k == 1) col_detect <= 1'b0;
            @(negedge sys_clk);
            shape[k] = alert;
        end
    endtask : detect
    // Wait for both readers and compare
    task automatic unload(input logic [77:0] exp, input logic [77:0] mask);
        int n;
        for (n = 0; n < 400 && !(c_done === 1'b1 && j_done === 1'b1); n++) @(negedge sys_clk);
        if (n == 400) check("unload wait", 78'h0, 78'h1);
        if (n == 400) wrap_up();
        check("core report", exp & mask, c_rep & mask);
        check("jtag report", exp & mask, j_rep & mask);
        @(posedge sys_clk);
        pulses <= 2'd0;
    endtask : unload
    // Located upset: two pulses, frame result, optional scrub, readout
    task automatic located(input logic [7:0] i, input logic [2:0] ct, input logic [2:0] ft);
        logic [8:0] shape;
        detect(i, ct, shape);
        check("alert shape", 78'h11f, {69'h0, shape});
        @(posedge sys_clk);
        {frm_done, frm_type, frm_dw, frm_bit} <= {1'b1, ft, 10'h3c0 + i, i[4:0] + 5'h3};
        frm_synd <= {24'hdead00, i};
        @(posedge sys_clk);
        frm_done <= 1'b0;
        @(negedge sys_clk);
        check("alert after frame", 78'h0, {77'h0, alert});
        check("scrub request", {77'h0, i[0] && ((decode_kind(ft) & 3'h3) != 3'h0)},
            {77'h0, scrub_req});
        unload(col_exp(i, ct) | {2'h0, ft, i[4:0] + 5'h3, 10'h3c0 + i, 24'hdead00, i, 26'h0},
            {78{1'b1}});
    endtask : located
    // Unlocatable upset: one pulse, column part only
    task automatic single_event;
        logic [8:0] shape;
        detect(8'h2c, 3'h7, shape);
        check("single shape", 78'h01f, {69'h0, shape});
        unload(col_exp(8'h2c, 3'h7), {1'b1, 51'h0, 26'h3ffffff});
    endtask : single_event
    // NRST reset in mid-sequence clears outputs
    task automatic reset_mid;
        logic [8:0] shape;
        @(posedge sys_clk);
        col_detect <= 1'b1;
        @(posedge sys_clk);
        col_detect <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b0;
        @(negedge sys_clk);
        check("outputs in reset", 78'h0, {75'h0, alert, busy, scrub_req});
        @(posedge sys_clk);
        nrst <= 1'b1;
    endtask : reset_mid
    // Main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 1; i < 7; i++) located(8'(i * 5), 3'(i), ftab[i]);
        single_event();
        reset_mid();
        located(8'h40, 3'h2, 3'h3);
        wrap_up();
    end
endmodule : tb_top
